// ---- counter_core_params.svh ----
// constants for the timer/event counter core: bit positions, codes, reset values
`ifndef COUNTER_CORE_PARAMS_SVH
`define COUNTER_CORE_PARAMS_SVH

// control byte field positions
`define CTRL_MODE_HI      7
`define CTRL_MODE_LO      6
`define CTRL_RUN_BIT      4
`define CTRL_EDGE_BIT     3

// mode pair encodings
`define MODE_IDLE         2'h0
`define MODE_EVENT        2'h1
`define MODE_TIMER        2'h2
`define MODE_PULSE        2'h3

// interrupt control byte field positions
`define INTC_GLOBAL_BIT   0
`define INTC_T0_EN_BIT    2
`define INTC_T0_FLAG_BIT  5

// reset values and limits
`define CTRL_RESET        8'h00
`define INTC_RESET        8'h00
`define COUNT_RESET       16'h0000
`define COUNT_MAX         16'hffff
`define TMR0_VECTOR       8'h08
`define VECTOR_NONE       8'h00

`endif

// ---- counter_core_pkg.sv ----
// types shared by the timer/event counter core and its pin synchroniser
`default_nettype none
package counter_core_pkg;

  // pulse width measurement sequencing
  typedef enum logic {
    PW_ARMED,
    PW_MEASURE
  } pw_state_t;

  // whole state of the core
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  intc;
    logic [15:0] count;
    logic [15:0] preload;
    pw_state_t   pw;
    logic        irq;
    logic        wake;
    logic [7:0]  vector;
  } core_state_t;

  // whole state of the pin synchroniser
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_state_t;

endpackage
`default_nettype wire

// ---- timer_pin_sync.sv ----
// two-flop synchroniser for the external timer pin plus one history stage
`default_nettype none
module timer_pin_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin_async,
  output logic      pin_level,
  output logic      pin_prev
);
  import counter_core_pkg::*;

  sync_state_t st;   // registered state
  sync_state_t nx;   // next state

  ////////////////////////////////////////////////////////////////////////////
  // next state: s1 is read only by s2, so metastability never reaches logic
  always_comb begin
    nx    = st;
    nx.s1 = pin_async;
    nx.s2 = st.s1;
    nx.s3 = st.s2;     // history for edge detection downstream
  end

  // register the state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // stages start at the pin's idle high level, so leaving reset shows no false edge;
      // a pin that idles low instead gives one spurious falling edge after reset
      st <= '1;
    end else begin
      st <= nx;
    end
  end

  assign pin_level = st.s2;
  assign pin_prev  = st.s3;

endmodule
`default_nettype wire

// ---- timer_event_counter_core.sv ----
// 16-bit timer / event counter / pulse width counter with overflow reload and wake
`include "counter_core_params.svh"
`default_nettype none
module timer_event_counter_core (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       timer_pin,                // external event / pulse input
  input  wire logic       power_down,               // device halted
  input  wire logic       ctrl_wr,                  // control byte write strobe
  input  wire logic [7:0] ctrl_wdata,
  input  wire logic       preload_lo_wr,            // preload low byte write strobe
  input  wire logic       preload_hi_wr,            // preload high byte write strobe
  input  wire logic [7:0] preload_wdata,
  input  wire logic       count_rd,                 // counter read strobe
  input  wire logic       intc_wr,                  // interrupt control write strobe
  input  wire logic [7:0] intc_wdata,
  output logic      [7:0] counter0_control,
  output logic      [7:0] interrupt_control_first,
  output logic      [7:0] counter0_low_byte,
  output logic      [7:0] counter0_high_byte,
  output logic            irq,
  output logic      [7:0] irq_vector,
  output logic            wake
);
  import counter_core_pkg::*;

  core_state_t st;         // registered state
  core_state_t nx;         // next state
  logic        pin_level;  // synchronised pin level
  logic        pin_prev;   // level one sample earlier
  logic [1:0]  mode;       // decoded mode pair
  logic        run;        // run-enable bit
  logic        edge_sel;   // active edge / level select
  logic        inhibit;    // counter clock inhibit
  logic        pin_rise;   // synchronised rising edge
  logic        pin_fall;   // synchronised falling edge
  logic        inc;        // count this cycle
  logic        ovf;        // overflow this cycle
  logic        pw_end;     // pulse returned to idle level

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser: the pin is asynchronous to the system clock
  timer_pin_sync u_sync (
    .clk       (clk),
    .rst_n     (rst_n),
    .pin_async (timer_pin),
    .pin_level (pin_level),
    .pin_prev  (pin_prev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state logic
  always_comb begin
    nx       = st;
    mode     = st.ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
    run      = st.ctrl[`CTRL_RUN_BIT];
    edge_sel = st.ctrl[`CTRL_EDGE_BIT];
    // an access in flight freezes the count; costs a count, avoids torn values
    inhibit  = count_rd | preload_lo_wr | preload_hi_wr;
    pin_rise = pin_level & ~pin_prev;
    pin_fall = ~pin_level & pin_prev;
    inc      = 1'b0;
    pw_end   = 1'b0;

    // count qualification per mode
    unique case (mode)
      `MODE_IDLE: begin
        inc = 1'b0;
      end
      `MODE_EVENT: begin
        // low select counts rising, high select counts falling;
        // keeps running in power-down since the pin drives it
        inc = run & (edge_sel ? pin_fall : pin_rise);
      end
      `MODE_TIMER: begin
        // system clock halts in power-down, so timer mode freezes there
        inc = run & ~power_down;
      end
      `MODE_PULSE: begin
        // level seen only as sampled, so widths may be off by a clock
        if (run && st.pw == PW_MEASURE && !power_down) begin
          if (pin_level == edge_sel) begin
            inc = 1'b1;
          end else begin
            pw_end = 1'b1;
          end
        end
      end
    endcase
    inc = inc & ~inhibit;
    ovf = inc & (st.count == `COUNT_MAX);

    // counter: reload on overflow, else step
    if (ovf) begin
      nx.count = st.preload;
    end else if (inc) begin
      nx.count = st.count + 16'h0001;
    end

    // preload writes; a stopped counter takes the value directly
    if (preload_lo_wr) begin
      nx.preload[7:0] = preload_wdata;
      if (!run) begin
        nx.count[7:0] = preload_wdata;
      end
    end
    if (preload_hi_wr) begin
      nx.preload[15:8] = preload_wdata;
      if (!run) begin
        nx.count[15:8] = preload_wdata;
      end
    end

    // pulse measurement sequencing
    if (mode != `MODE_PULSE || !run) begin
      nx.pw = PW_ARMED;
    end else if (st.pw == PW_ARMED) begin
      // low select waits for a falling edge, high select for a rising edge
      if (edge_sel ? pin_rise : pin_fall) begin
        nx.pw = PW_MEASURE;
      end
    end else if (pw_end) begin
      nx.pw = PW_ARMED;
    end

    // control byte: hardware ends a pulse, a software write in the same cycle wins
    if (pw_end) begin
      nx.ctrl[`CTRL_RUN_BIT] = 1'b0;
    end
    if (ctrl_wr) begin
      nx.ctrl = ctrl_wdata;
    end

    // interrupt control: overflow set beats a software clear
    if (intc_wr) begin
      nx.intc = intc_wdata;
    end
    if (ovf) begin
      nx.intc[`INTC_T0_FLAG_BIT] = 1'b1;
    end

    // interrupt line and vector, gated by both enables
    nx.irq = st.intc[`INTC_T0_FLAG_BIT] & st.intc[`INTC_T0_EN_BIT]
           & st.intc[`INTC_GLOBAL_BIT];
    nx.vector = nx.irq ? `TMR0_VECTOR : `VECTOR_NONE;

    // wake ignores the enables; a flag already pending blocks it
    nx.wake = ovf & power_down & ~st.intc[`INTC_T0_FLAG_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // register the state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st         <= '0;
      st.ctrl    <= `CTRL_RESET;
      st.intc    <= `INTC_RESET;
      st.count   <= `COUNT_RESET;
      st.preload <= `COUNT_RESET;
      st.pw      <= PW_ARMED;
      st.vector  <= `VECTOR_NONE;
    end else begin
      st <= nx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from state flops
  assign counter0_control        = st.ctrl;
  assign interrupt_control_first = st.intc;
  assign counter0_low_byte       = st.count[7:0];
  assign counter0_high_byte      = st.count[15:8];
  assign irq                     = st.irq;
  assign irq_vector              = st.vector;
  assign wake                    = st.wake;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // timer mode steps by one each clock
  timer_step_a: assert property (
    (mode == `MODE_TIMER && run && !power_down && !inhibit && !ctrl_wr
     && st.count != `COUNT_MAX)
    |=> st.count == $past(st.count) + 16'h0001) else $error("timer step wrong");

  // overflow reloads the preload value
  ovf_reload_a: assert property (
    ovf |=> st.count == $past(st.preload)) else $error("no reload");

  // overflow sets the request flag
  ovf_flag_a: assert property (
    ovf |=> st.intc[`INTC_T0_FLAG_BIT]) else $error("flag not set");

  // interrupt needs the enable, vector follows it
  irq_gate_a: assert property (
    !st.intc[`INTC_T0_EN_BIT] |=> !irq ##0 irq_vector == `VECTOR_NONE)
    else $error("irq without enable");

  // enabled pending flag yields the vector
  irq_vector_a: assert property (
    (st.intc[`INTC_T0_FLAG_BIT] && st.intc[`INTC_T0_EN_BIT] && st.intc[`INTC_GLOBAL_BIT])
    |=> irq && irq_vector == `TMR0_VECTOR) else $error("vector wrong");

  // power-down overflow wakes when no flag pending
  wake_pd_a: assert property (
    (ovf && power_down && !st.intc[`INTC_T0_FLAG_BIT]) |=> wake)
    else $error("missing wake");

  // pending flag suppresses wake
  wake_block_a: assert property (
    st.intc[`INTC_T0_FLAG_BIT] |=> !wake) else $error("wake despite flag");

  // counter read freezes the counter
  read_inhibit_a: assert property (
    (count_rd && !preload_lo_wr && !preload_hi_wr) |=> $stable(st.count))
    else $error("count moved during read");

  // idle mode or stopped counter holds unless the preload is written
  idle_hold_a: assert property (
    ((mode == `MODE_IDLE || !run) && !preload_lo_wr && !preload_hi_wr)
    |=> $stable(st.count)) else $error("idle counter moved");

  // pulse end clears run and rearms the edge wait
  pw_stop_a: assert property (
    (mode == `MODE_PULSE && run && st.pw == PW_MEASURE && !power_down
     && pin_level != edge_sel && !ctrl_wr)
    |=> !st.ctrl[`CTRL_RUN_BIT] && st.pw == PW_ARMED) else $error("pulse not ended");

  // event edge counted one clock later
  event_edge_a: assert property (
    (mode == `MODE_EVENT && run && (edge_sel ? pin_fall : pin_rise) && !inhibit
     && st.count != `COUNT_MAX && !ctrl_wr)
    |=> st.count == $past(st.count) + 16'h0001) else $error("event missed");

  cover_ovf_c:    cover property (ovf ##1 irq);
  cover_wake_c:   cover property (power_down && ovf ##1 wake);
  cover_pulse_c:  cover property (st.pw == PW_MEASURE ##[1:20] pw_end);
  cover_event_c:  cover property (mode == `MODE_EVENT && inc);

endmodule
`default_nettype wire

// ---- pin_source.sv ----
// behavioural source of pulses and events on the external timer pin
`default_nettype none
module pin_source (
  input  wire logic       clk,
  input  wire logic       go,     // start one burst
  input  wire logic [7:0] width,  // cycles low, then cycles high, per pulse
  input  wire logic [7:0] pulses, // pulses in one burst
  output logic            pin,    // idles high between bursts
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int n; // pulses sent so far
  ////////////////////////////////////////////////////////////////////////////////
  // pin moves just after a rising edge, by non-blocking assignment like every other input
  initial begin
    pin  = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'b1;
        for (n = 0; n < pulses; n++) begin
          pin <= 1'b0;
          repeat (width) @(posedge clk);
          pin <= 1'b1;
          repeat (width) @(posedge clk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the timer/event counter core
`include "counter_core_params.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, pin, busy, go = 0, power_down = 0, ctrl_wr = 0, count_rd = 0;
  logic       pre_lo_wr = 0, pre_hi_wr = 0, intc_wr = 0, irq, wake;
  logic [7:0] ctrl_wdata = 0, pre_wdata = 0, intc_wdata = 0, width = 0, pulses = 0;
  logic [7:0] ctrl_q, intc_q, lo_q, hi_q, vec_q;
  int         err_total = 0, checked = 0, wake_cnt = 0, i;
  logic [15:0] base;
  ////////////////////////////////////////////////////////////////////////////////
  // clock at 8 ns period
  always #4 clk = ~clk;
  // count wake pulses, one per qualifying overflow
  always @(posedge clk) if (wake === 1'b1) wake_cnt++;
  timer_event_counter_core dut (
    .clk(clk), .rst_n(rst_n), .timer_pin(pin), .power_down(power_down),
    .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .preload_lo_wr(pre_lo_wr),
    .preload_hi_wr(pre_hi_wr), .preload_wdata(pre_wdata), .count_rd(count_rd),
    .intc_wr(intc_wr), .intc_wdata(intc_wdata), .counter0_control(ctrl_q),
    .interrupt_control_first(intc_q), .counter0_low_byte(lo_q),
    .counter0_high_byte(hi_q), .irq(irq), .irq_vector(vec_q), .wake(wake));
  pin_source src (.clk(clk), .go(go), .width(width), .pulses(pulses), .pin(pin), .busy(busy));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (err_total == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // wait edges, then step past them so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_ctrl(input logic [7:0] v);
    @(posedge clk) begin ctrl_wr <= 1; ctrl_wdata <= v; end
    @(posedge clk) ctrl_wr <= 0;
    #1;
  endtask
  task automatic wr_intc(input logic [7:0] v);
    @(posedge clk) begin intc_wr <= 1; intc_wdata <= v; end
    @(posedge clk) intc_wr <= 0;
    #1;
  endtask
  // preload both bytes; with run clear this also loads the counter
  task automatic wr_pre(input logic [15:0] v);
    @(posedge clk) begin pre_lo_wr <= 1; pre_wdata <= v[7:0]; end
    @(posedge clk) begin pre_lo_wr <= 0; pre_hi_wr <= 1; pre_wdata <= v[15:8]; end
    @(posedge clk) pre_hi_wr <= 0;
    cyc(1);
  endtask
  // burst of pulses from the pin source, waited for under a bound
  task automatic burst(input logic [7:0] w, input logic [7:0] p);
    @(posedge clk) begin go <= 1; width <= w; pulses <= p; end
    @(posedge clk) go <= 0;
    #1;
    for (i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge clk);
    if (busy !== 1'b0) err_total++;
    cyc(4);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // timer start sequence, run/stop and counting inhibit on reads
  task automatic t_timer();
    check({ctrl_q, intc_q}, 16'h0000);
    wr_pre(16'h9b1f);
    check({hi_q, lo_q}, 16'h9b1f);
    wr_ctrl(8'h80);
    cyc(5);
    check({ctrl_q, hi_q}, 16'h809b);
    check(lo_q, 8'h1f);
    wr_ctrl(8'h90);
    base = {hi_q, lo_q};
    cyc(10);
    check({hi_q, lo_q} - base, 16'h000a);
    base = {hi_q, lo_q};
    cyc(3);
    @(posedge clk) count_rd <= 1;
    repeat (3) @(posedge clk);
    count_rd <= 0;
    cyc(3);
    check({hi_q, lo_q} - base, 16'h0007);
    wr_ctrl(8'h80);
    base = {hi_q, lo_q};
    cyc(10);
    check({hi_q, lo_q}, base);
  endtask
  // overflow, reload, request flag, enabled and disabled interrupt
  task automatic t_irq();
    wr_pre(16'hfffe);
    wr_intc(8'h05);
    wr_ctrl(8'h90);
    for (i = 0; i < 20 && intc_q[`INTC_T0_FLAG_BIT] !== 1'b1; i++) cyc(1);
    check(intc_q[`INTC_T0_FLAG_BIT], 1'b1);
    cyc(3);
    check({7'h00, irq, vec_q}, {8'h01, `TMR0_VECTOR});
    check(hi_q, 8'hff);
    wr_ctrl(8'h80);
    wr_intc(8'h01);
    wr_pre(16'hfffe);
    wr_ctrl(8'h90);
    cyc(10);
    check({intc_q[`INTC_T0_FLAG_BIT], irq}, 2'b10);
    wr_ctrl(8'h80);
  endtask
  // event counting on both edges, and mode 00 holding the counter
  task automatic t_event();
    wr_pre(16'h0000);
    wr_ctrl(8'h40);
    wr_ctrl(8'h50);
    burst(8'h04, 8'h05);
    check({hi_q, lo_q}, 16'h0005);
    wr_ctrl(8'h48);
    wr_pre(16'h0000);
    wr_ctrl(8'h58);
    burst(8'h04, 8'h05);
    check({hi_q, lo_q}, 16'h0005);
    wr_ctrl(8'h00);
    wr_pre(16'h0000);
    wr_ctrl(8'h10);
    burst(8'h04, 8'h03);
    check({hi_q, lo_q}, 16'h0000);
  endtask
  // overflow in power-down wakes unless the flag was already set
  task automatic t_wake();
    wr_ctrl(8'h40);
    wr_intc(8'h00);
    wr_pre(16'hfffd);
    wr_ctrl(8'h50);
    @(posedge clk) power_down <= 1;
    wake_cnt = 0;
    burst(8'h04, 8'h04);
    check(wake_cnt, 1);
    check(lo_q, 8'hfe);
    burst(8'h04, 8'h04);
    check(wake_cnt, 1);
    @(posedge clk) power_down <= 0;
    wr_ctrl(8'h40);
  endtask
  // low pulse, then high pulse, measured; run cleared by hardware after each
  task automatic t_pulse();
    wr_ctrl(8'hc0);
    wr_pre(16'h0000);
    wr_ctrl(8'hd0);
    burst(8'h14, 8'h01);
    check({15'h0000, {hi_q, lo_q} >= 16'h0013 && {hi_q, lo_q} <= 16'h0015}, 16'h0001);
    check(ctrl_q, 8'hc0);
    // high select: waits for the rise, counts while high, ends at the fall
    wr_ctrl(8'hc8);
    wr_pre(16'h0000);
    wr_ctrl(8'hd8);
    burst(8'h14, 8'h02);
    check({15'h0000, {hi_q, lo_q} >= 16'h0013 && {hi_q, lo_q} <= 16'h0015}, 16'h0001);
    check(ctrl_q, 8'hc8);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    cyc(1);
    t_timer();
    t_irq();
    t_event();
    t_wake();
    t_pulse();
    results();
  end
  // watchdog, far beyond the few hundred cycles the scenarios take
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    results();
  end
endmodule
`default_nettype wire
